/* File: crc_clock_ready_irq_control.v */
// Design decisions made here: the Wishbone slave port and the address map.
`timescale 1ns/10ps
`default_nettype none
`include "crc_defs.vh"
module crc_clock_ready_irq_control (
    input  wire        clk_sys,
    input  wire        reset,
    input  wire        wb_cyc_i,
    input  wire        wb_stb_i,
    input  wire        wb_we_i,
    input  wire [3:0]  wb_adr_i,
    input  wire [3:0]  wb_sel_i,
    input  wire [31:0] wb_dat_i,
    output reg  [31:0] wb_dat_o,
    output reg         wb_ack_o,
    output wire        wb_err_o,
    input  wire        osc_fail_in,
    input  wire [3:0]  osc_ready_in,
    output wire        clock_irq,
    output wire        event_irq
);
    wire [4:0] sync_q;
    crc_sync #(.W(`CRC_EVT_W)) u_sync (
        .clk_sys (clk_sys),
        .reset   (reset),
        .d       ({osc_fail_in, osc_ready_in}),
        .q       (sync_q)
    );
    wire       fail_s  = sync_q[4];
    wire [3:0] ready_s = sync_q[3:0];

    reg        clock_failure_flag;
    reg [3:0]  ready_flag;
    reg [3:0]  ready_prev;
    reg        fail_prev;
    reg        low_speed_internal_ready_irq_en;
    reg        low_speed_external_ready_irq_en;
    reg        high_speed_internal_ready_irq_en;
    reg        high_speed_external_ready_irq_en;
    reg [4:0]  evt_stat;
    reg [4:0]  evt_mask;

    function sel_hit;
        input [3:0] sel;
        input integer bitpos;
        begin
            sel_hit = sel[bitpos/8];
        end
    endfunction

    wire req      = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    wire wr       = req & wb_we_i;
    wire mapped   = (wb_adr_i == `CRC_OFS_CTRL) | (wb_adr_i == `CRC_OFS_READY) |
                    (wb_adr_i == `CRC_OFS_EVT_STAT) | (wb_adr_i == `CRC_OFS_EVT_MASK);
    wire wr_ctrl  = wr & (wb_adr_i == `CRC_OFS_CTRL);
    wire wr_stat  = wr & (wb_adr_i == `CRC_OFS_EVT_STAT) & wb_sel_i[0];
    wire wr_mask  = wr & (wb_adr_i == `CRC_OFS_EVT_MASK) & wb_sel_i[0];
    wire fail_clr = wr_ctrl & sel_hit(wb_sel_i, `CRC_BIT_FAIL_CLR) &
                    wb_dat_i[`CRC_BIT_FAIL_CLR];
    wire en_wr    = wr_ctrl & sel_hit(wb_sel_i, `CRC_BIT_LSI_EN);
    assign wb_err_o = 1'b0;

    wire [3:0] ready_rise = ready_s & ~ready_prev;
    wire       fail_rise  = fail_s & ~fail_prev;
    wire [3:0] en_vec = {high_speed_external_ready_irq_en, high_speed_internal_ready_irq_en,
                         low_speed_external_ready_irq_en, low_speed_internal_ready_irq_en};

    always @(posedge clk_sys) begin
        if (reset) begin
            clock_failure_flag <= 1'b0;
            ready_flag <= `CRC_RDY_RESET;
            ready_prev <= 4'h0;
            fail_prev  <= 1'b0;
            low_speed_internal_ready_irq_en  <= 1'b0;
            low_speed_external_ready_irq_en  <= 1'b0;
            high_speed_internal_ready_irq_en <= 1'b0;
            high_speed_external_ready_irq_en <= 1'b0;
            evt_stat <= `CRC_EVT_RESET;
            evt_mask <= `CRC_EVT_MASK_RESET;
        end else begin
            ready_prev <= ready_s;
            fail_prev  <= fail_s;
            // set beats clear when failure lands with the clear write
            if (fail_s)
                clock_failure_flag <= 1'b1;
            else if (fail_clr)
                clock_failure_flag <= 1'b0;
            // ready flags latch; cleared only by reset here
            ready_flag <= ready_flag | ready_rise;
            if (en_wr) begin
                low_speed_internal_ready_irq_en  <= wb_dat_i[`CRC_BIT_LSI_EN];
                low_speed_external_ready_irq_en  <= wb_dat_i[`CRC_BIT_LSE_EN];
                high_speed_internal_ready_irq_en <= wb_dat_i[`CRC_BIT_HSI_EN];
                high_speed_external_ready_irq_en <= wb_dat_i[`CRC_BIT_HS_EXT_EN];
            end
            if (wr_mask)
                evt_mask <= wb_dat_i[`CRC_EVT_W-1:0];
            evt_stat <= (evt_stat & ~(wr_stat ? wb_dat_i[`CRC_EVT_W-1:0] : 5'h00))
                        | {fail_rise, ready_rise};
        end
    end

    assign clock_irq = (|(ready_flag & en_vec)) | clock_failure_flag;
    assign event_irq = |(evt_stat & evt_mask);

    always @(posedge clk_sys) begin
        if (reset) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0000_0000;
        end else begin
            wb_ack_o <= req;
            wb_dat_o <= 32'h0000_0000;
            if (req & ~wb_we_i & mapped) begin
                case (wb_adr_i)
                    `CRC_OFS_CTRL: begin
                        wb_dat_o[`CRC_BIT_FAIL_FLAG] <= clock_failure_flag;
                        wb_dat_o[`CRC_BIT_HS_EXT_EN:`CRC_BIT_LSI_EN] <= en_vec;
                    end
                    `CRC_OFS_READY: begin
                        wb_dat_o[`CRC_BIT_RDY_HS_EXT:`CRC_BIT_RDY_LSI] <= ready_flag;
                    end
                    `CRC_OFS_EVT_STAT: wb_dat_o[4:0] <= evt_stat;
                    `CRC_OFS_EVT_MASK: wb_dat_o[4:0] <= evt_mask;
                    default:           wb_dat_o <= 32'h0000_0000;
                endcase
            end
        end
    end
endmodule
`default_nettype wire

/* File: crc_defs.vh */
`ifndef CRC_DEFS_VH
`define CRC_DEFS_VH
`define CRC_ADDR_W          4
`define CRC_OFS_CTRL        4'h0
`define CRC_OFS_READY       4'h4
`define CRC_OFS_EVT_STAT    4'h8
`define CRC_OFS_EVT_MASK    4'hc
`define CRC_BIT_FAIL_FLAG   7
`define CRC_BIT_LSI_EN      8
`define CRC_BIT_LSE_EN      9
`define CRC_BIT_HSI_EN      10
`define CRC_BIT_HS_EXT_EN   11
`define CRC_BIT_FAIL_CLR    23
`define CRC_BIT_RDY_LSI     0
`define CRC_BIT_RDY_LSE     1
`define CRC_BIT_RDY_HSI     2
`define CRC_BIT_RDY_HS_EXT  3
`define CRC_EN_RESET        4'h0
`define CRC_RDY_RESET       4'h0
`define CRC_EVT_W           5
`define CRC_EVT_RESET       5'h00
`define CRC_EVT_MASK_RESET  5'h00
`endif

/* File: crc_sync.v */
`timescale 1ns/10ps
`default_nettype none
module crc_sync #(
    parameter W = 5
) (
    input  wire         clk_sys,
    input  wire         reset,
    input  wire [W-1:0] d,
    output reg  [W-1:0] q
);
    reg [W-1:0] meta;
    always @(posedge clk_sys) begin
        if (reset) begin
            meta <= {W{1'b0}};
            q    <= {W{1'b0}};
        end else begin
            meta <= d;
            q    <= meta;
        end
    end
endmodule
`default_nettype wire

/* File: crc_props_properties.sv */
`timescale 1ns/10ps
`default_nettype none
module crc_props (
    input wire logic        clk_sys,
    input wire logic        reset,
    input wire logic        wb_cyc_i,
    input wire logic        wb_stb_i,
    input wire logic        wb_we_i,
    input wire logic        wb_ack_o,
    input wire logic [3:0]  wb_adr_i,
    input wire logic [3:0]  wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic        osc_fail_in,
    input wire logic [3:0]  osc_ready_in,
    input wire logic        clock_irq
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (reset);
    // write seen at its ack, while the master still holds the data
    wire logic wr = wb_ack_o && wb_we_i && wb_adr_i == 4'h0;
    property p_gate(int k);
        osc_ready_in[k] [*4] ##0 (wr && wb_sel_i[1] && wb_dat_i[8+k]) |-> clock_irq;
    endproperty
    a_fail_sets_irq: assert property (osc_fail_in [*3] |=> clock_irq) else $error("no fail irq");
    a_clear_drops_irq: assert property (!osc_fail_in [*4] ##0 (wr && wb_sel_i == 4'hf
        && wb_dat_i[23] && wb_dat_i[11:8] == 4'h0) |-> !clock_irq) else $error("irq kept");
    a_lsi_gate: assert property (p_gate(0)) else $error("lsi gate");
    a_lse_gate: assert property (p_gate(1)) else $error("lse gate");
    a_hsi_gate: assert property (p_gate(2)) else $error("hsi gate");
    a_hs_ext_gate: assert property (p_gate(3)) else $error("hs ext gate");
    a_irq_fall_cause: assert property ($fell(clock_irq) |-> wr) else $error("irq fell");
    a_ack_answer: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("no ack");
    cover property (clock_irq && wr);
    cover property ($fell(clock_irq));
    cover property (osc_fail_in [*3] ##1 clock_irq);
endmodule
bind crc_clock_ready_irq_control crc_props u_crc_props (
    .clk_sys      (clk_sys),
    .reset        (reset),
    .wb_cyc_i     (wb_cyc_i),
    .wb_stb_i     (wb_stb_i),
    .wb_we_i      (wb_we_i),
    .wb_ack_o     (wb_ack_o),
    .wb_adr_i     (wb_adr_i),
    .wb_sel_i     (wb_sel_i),
    .wb_dat_i     (wb_dat_i),
    .osc_fail_in  (osc_fail_in),
    .osc_ready_in (osc_ready_in),
    .clock_irq    (clock_irq)
);
`default_nettype wire

/* File: tb.sv */
`timescale 1ns/10ps
`default_nettype none
`define CHK(n, e, g) begin checked++; if ((g) !== (e)) begin error_cnt++; \
    $display("MISMATCH %s exp %h got %h", n, e, g); end end
module tb;
    logic        clk_sys = 0, reset = 1, cyc = 0, we = 0, fail = 0, ack, irq, eirq, err;
    logic [3:0]  adr = 0, rdy = 0, sel = 4'hf;
    logic [31:0] wd = 0, rd, dout;
    int          error_cnt = 0, checked = 0;
    crc_clock_ready_irq_control u_crc_clock_ready_irq_control (.clk_sys(clk_sys),
        .reset(reset), .wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_we_i(we), .wb_adr_i(adr),
        .wb_sel_i(sel), .wb_dat_i(wd), .wb_dat_o(dout), .wb_ack_o(ack), .wb_err_o(err),
        .osc_fail_in(fail), .osc_ready_in(rdy), .clock_irq(irq), .event_irq(eirq));
    initial forever #20 clk_sys = ~clk_sys;
    task automatic final_report;
        $display("errors %0d checks %0d", error_cnt, checked);
        if (error_cnt == 0 && checked > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    // entered right after a rising edge; ends one idle cycle after release
    task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
        int n;
        n = 0;
        cyc <= 1; we <= w; adr <= a; wd <= d;
        do begin @(posedge clk_sys); n++; end while (ack !== 1'b1 && n < 20);
        rd = dout;
        if (ack !== 1'b1) begin error_cnt++; final_report; end
        cyc <= 0;
        @(posedge clk_sys);
    endtask
    task automatic t_fail;
        bus(0, 4'h0, 0); `CHK("ctrl rst", 32'h0, rd)
        fail <= 1;
        repeat (4) @(posedge clk_sys);
        `CHK("irq", 1'b1, irq)
        bus(1, 4'hc, 32'h10); `CHK("eirq", 1'b1, eirq)
        bus(1, 4'h8, 32'h10); `CHK("eirq clr", 1'b0, eirq)
        // clear lands while failure still high: set must win
        bus(1, 4'h0, 32'h80_0000); `CHK("flag held", 1'b1, irq)
        fail <= 0;
        repeat (3) @(posedge clk_sys);
        bus(1, 4'h0, 32'h0); bus(0, 4'h0, 0); `CHK("flag", 1'b1, rd[7])
        bus(1, 4'h0, 32'h80_0000); `CHK("irq clr", 1'b0, irq)
        bus(0, 4'h0, 0); `CHK("flag clr", 1'b0, rd[7])
    endtask
    task automatic t_gate;
        rdy <= 4'hf;
        repeat (5) @(posedge clk_sys);
        `CHK("irq off", 1'b0, irq)
        for (int k = 0; k < 4; k++) begin
            bus(1, 4'h0, 32'h1 << (8 + k)); `CHK("irq en", 1'b1, irq)
            bus(0, 4'h0, 0); `CHK("en rd", 4'h1 << k, rd[11:8])
        end
        bus(0, 4'h4, 0); `CHK("ready", 32'hf, rd)
        bus(0, 4'h8, 0); `CHK("evt stat", 32'hf, rd)
        bus(0, 4'hc, 0); `CHK("evt mask", 32'h10, rd)
        `CHK("eirq off", 1'b0, eirq)
        bus(1, 4'h0, 0); `CHK("irq dis", 1'b0, irq)
        // enables sit in lane 1; a lane 0 write must leave them alone
        sel <= 4'h1;
        bus(1, 4'h0, 32'hf00); `CHK("sel gate", 1'b0, irq)
        sel <= 4'hf;
        bus(0, 4'h2, 0); `CHK("unmapped", 32'h0, rd)
        `CHK("err", 1'b0, err)
    endtask
    initial begin
        repeat (3) @(posedge clk_sys);
        reset <= 0;
        @(posedge clk_sys);
        t_fail;
        t_gate;
        final_report;
    end
endmodule
`default_nettype wire
